// File: rtl/vidcap_pkg.sv
package vidcap_pkg;
  // Register index of the vertical delay register.
  localparam logic [7:0] REG_VSYNC_DELAY = 8'h09;
  localparam logic [7:0] VSYNC_DELAY_RESET = 8'h3a;
  // Programmable vertical delay step in system clocks.
  localparam int VSYNC_STEP_CLKS = 32;
  // Fixed input pipeline of the vertical path, least and most clocks.
  localparam int VSYNC_FIXED_MIN = 7;
  localparam int VSYNC_FIXED_MAX = 11;
  // Horizontal timing to first active pixel.
  localparam int HSYNC_COARSE_STEP = 64;
  localparam int HSYNC_FIXED_CLKS = 65;
  // Active pixels per input line.
  localparam int LUMA_PIXELS = 720;
  localparam int CHROMA_PIXELS = 180;
  // Synchroniser stages ahead of the edge logic.
  localparam int SYNC_STAGES = 2;
  // Field identification: an hsync more than half this count after the internal vertical edge marks field B.
  localparam int FIELD_SAMPLE_CLKS = 864;

  typedef struct packed {
    logic [7:0] luma;
    logic [3:0] chroma;
  } vidcap_pixel_t;

  typedef struct packed {
    logic [7:0] u;
    logic [7:0] v;
  } vidcap_chroma_t;

  typedef struct packed {
    logic hsync_in_polarity;
    logic vsync_in_polarity;
    logic chroma_in_signed;
    logic chroma_out_signed;
  } vidcap_cfg_t;
endpackage

// File: rtl/vidcap_top.sv
// Summary of operation
// RULE1: Luma enters as one full 8-bit sample per pixel on eight lines.
// RULE2: Chroma 4:1:1 over four samples, U pairs on upper lines, V on lower.
// RULE3: Output luma and chroma use the same 4:1:1 arrangement as input.
// RULE4: Input and output chroma each unsigned or two's complement by own bit.
// RULE5: System clock supplied must not exceed 27 MHz.
// RULE6: Sync edges are recognised only while the active-low gate is low.
// RULE7: Slow frontends drive half-rate clock on gate; fast ones tie it low.
// RULE8: Horizontal and vertical syncs are sampled with the full-rate clock.
// RULE9: Half-rate enable samples pixel data; quarter-rate enable runs blocks.
// RULE10: Eighth-rate enable aligns the four-sample chroma group.
// RULE11: Fixed capture of 720 luma and 180 chroma pixels per line.
// RULE12: Each sync input has its own polarity setting.
// RULE13: Vertical sync delayed in steps of 32 clocks set by register.
// RULE14: Fixed vertical input delay of 7 to 11 clocks by quarter phase.
// RULE15: Vertical delay register resets to 3A hexadecimal.
// RULE16: Software places internal vertical falling edge in line 2 of field A.
// RULE17: Field A or B identified by sampling relative to internal syncs.
// RULE18: Output alpha-alpha-beta-beta fields or progressive frames from one field; here the interlace flag alternates per field, stays low if progressive.
// RULE19: Output vertical, horizontal, active-video and interlace signals.
// RULE20: System applies active-low reset at least two clocks long.
// RULE21: Software sets coarse delay and pixel phase to match the frontend.
// RULE22: First pixel arrives 64 times coarse plus phase plus 65 clocks after edge.
// RULE23: Blank-line counter counts horizontal syncs from internal vertical fall.
// RULE24: Internal vertical delay is register times 32 plus input delay.
// RULE25: Rate clocks are enables from a free divider restarted by reset.
module vidcap_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Sync pins
  input wire logic i_hsync_in,
  input wire logic i_vsync_in,
  input wire logic i_sync_gate_n,
  // Pixel pins
  input wire logic [7:0] i_luma_in,
  input wire logic [3:0] i_chroma_in,
  // Configuration
  input wire vidcap_pkg::vidcap_cfg_t i_cfg,
  input wire logic [7:0] i_hsync_delay_coarse,
  input wire logic [5:0] i_input_pixel_phase,
  // Register port
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Output mode, low selects field-repeat interlaced
  input wire logic i_mode_progressive,
  // Video outputs
  output logic [7:0] o_luma_out,
  output logic [3:0] o_chroma_out,
  output logic o_active_video_out,
  output logic o_hsync_out,
  output logic o_vsync_out,
  output logic o_interlaced,
  // Status
  output logic o_internal_vsync,
  output logic o_internal_hsync,
  output logic o_field_b,
  output logic [9:0] o_input_blank_lines,
  output logic [9:0] o_pixel_count
);
  logic [7:0] vsync_delay;
  logic [2:0] div;
  logic half_rate_clock;
  logic quarter_rate_clock;
  logic eighth_rate_clock;
  logic [vidcap_pkg::SYNC_STAGES-1:0] hs_sync;
  logic [vidcap_pkg::SYNC_STAGES-1:0] vs_sync;
  logic [vidcap_pkg::SYNC_STAGES-1:0] gate_sync;
  logic hs_q;
  logic vs_q;
  logic hs_edge;
  logic vs_edge;
  logic vs_act;
  logic vs_act_q;
  logic [15:0] hcnt;
  logic h_armed;
  logic [15:0] first_pix;
  logic capturing;
  logic [1:0] grp;
  logic [13:0] vdly_cnt;
  logic vdly_run;
  logic vs_lvl;
  logic internal_vsync;
  logic [9:0] blank_cnt;
  logic [11:0] fid_cnt;
  logic fid_run;
  logic field_b;
  logic [1:0] out_phase;
  vidcap_pkg::vidcap_chroma_t cap_uv;
  vidcap_pkg::vidcap_chroma_t out_uv;
  logic [7:0] luma_q;
  logic [7:0] luma_cap;
  logic [3:0] chroma_q;

  // Flips the top bit to convert between unsigned and two's complement.
  function automatic logic [7:0] conv_fmt(input logic [7:0] x, input logic sgn);
    conv_fmt = sgn ? {~x[7], x[6:0]} : x;
  endfunction

  // RULE15: reset value
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vsync_delay <= vidcap_pkg::VSYNC_DELAY_RESET;
    end else if (i_reg_we && i_reg_addr == vidcap_pkg::REG_VSYNC_DELAY) begin
      vsync_delay <= i_reg_wdata;
    end
  end

  always_comb begin
    o_reg_rdata = (i_reg_addr == vidcap_pkg::REG_VSYNC_DELAY) ? vsync_delay : 8'h00;
  end

  // RULE25: free divider
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end

  // RULE9: half and quarter enables
  assign half_rate_clock = div[0];
  assign quarter_rate_clock = div[1:0] == 2'h3;
  // RULE10: eighth enable
  assign eighth_rate_clock = div == 3'h7;

  // RULE8: full-rate sampling
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hs_sync <= '0;
      vs_sync <= '0;
      gate_sync <= '1;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
    end else begin
      hs_sync <= {hs_sync[0], i_hsync_in};
      vs_sync <= {vs_sync[0], i_vsync_in};
      gate_sync <= {gate_sync[0], i_sync_gate_n};
      // RULE6: gated sampling
      if (!gate_sync[1]) begin
        // RULE12: polarity
        hs_q <= hs_sync[1] ^ i_cfg.hsync_in_polarity;
        vs_q <= vs_sync[1] ^ i_cfg.vsync_in_polarity;
      end
    end
  end

  // Active edge is a fall of the polarity-normalised level.
  logic hs_norm;
  logic vs_norm;
  assign hs_norm = hs_sync[1] ^ i_cfg.hsync_in_polarity;
  assign vs_norm = vs_sync[1] ^ i_cfg.vsync_in_polarity;
  assign hs_edge = !gate_sync[1] && hs_q && !hs_norm;
  assign vs_edge = !gate_sync[1] && vs_q && !vs_norm;

  // RULE22: horizontal timing
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hcnt <= 16'h0000;
      h_armed <= 1'b0;
      first_pix <= 16'h0000;
    end else if (hs_edge) begin
      // The count starts at the pin edge, so it covers the synchroniser and the edge compare.
      hcnt <= 16'(vidcap_pkg::SYNC_STAGES + 1);
      h_armed <= 1'b1;
      first_pix <= 16'(int'(i_hsync_delay_coarse) * vidcap_pkg::HSYNC_COARSE_STEP
        + int'(i_input_pixel_phase) + vidcap_pkg::HSYNC_FIXED_CLKS);
    end else if (h_armed) begin
      hcnt <= hcnt + 16'h0001;
      if (hcnt == first_pix) begin
        h_armed <= 1'b0;
      end
    end
  end

  assign o_internal_hsync = hs_edge;

  // RULE11: fixed pixel count
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      capturing <= 1'b0;
      o_pixel_count <= 10'h000;
    end else if (h_armed && hcnt == first_pix) begin
      capturing <= 1'b1;
      o_pixel_count <= 10'h000;
    end else if (capturing && half_rate_clock) begin
      if (o_pixel_count == 10'(vidcap_pkg::LUMA_PIXELS - 1)) begin
        capturing <= 1'b0;
      end
      o_pixel_count <= o_pixel_count + 10'h001;
    end
  end

  // RULE1: luma sampling
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      luma_q <= 8'h00;
      chroma_q <= 4'h0;
      luma_cap <= 8'h00;
      grp <= 2'h0;
      cap_uv <= '0;
    end else begin
      luma_q <= i_luma_in;
      chroma_q <= i_chroma_in;
      // RULE9: half-rate data capture
      if (half_rate_clock && capturing) begin
        luma_cap <= luma_q;
        grp <= grp + 2'h1;
        // RULE2: chroma bit pairs
        case (grp)
          2'h0: begin
            cap_uv.u[7:6] <= chroma_q[3:2];
            cap_uv.v[7:6] <= chroma_q[1:0];
          end
          2'h1: begin
            cap_uv.u[5:4] <= chroma_q[3:2];
            cap_uv.v[5:4] <= chroma_q[1:0];
          end
          2'h2: begin
            cap_uv.u[3:2] <= chroma_q[3:2];
            cap_uv.v[3:2] <= chroma_q[1:0];
          end
          default: begin
            cap_uv.u[1:0] <= chroma_q[3:2];
            cap_uv.v[1:0] <= chroma_q[1:0];
          end
        endcase
      end else if (!capturing) begin
        // RULE10: group realigned before each line
        grp <= 2'h0;
      end
    end
  end

  // RULE4: format conversion per group
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      out_uv <= '0;
    end else if (eighth_rate_clock) begin
      out_uv.u <= conv_fmt(conv_fmt(cap_uv.u, i_cfg.chroma_in_signed), i_cfg.chroma_out_signed);
      out_uv.v <= conv_fmt(conv_fmt(cap_uv.v, i_cfg.chroma_in_signed), i_cfg.chroma_out_signed);
    end
  end

  // RULE3: output arrangement
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_luma_out <= 8'h00;
      o_chroma_out <= 4'h0;
      out_phase <= 2'h0;
      o_active_video_out <= 1'b0;
    end else if (half_rate_clock) begin
      o_luma_out <= luma_cap;
      o_active_video_out <= capturing;
      out_phase <= capturing ? out_phase + 2'h1 : 2'h0;
      case (out_phase)
        2'h0: o_chroma_out <= {out_uv.u[7:6], out_uv.v[7:6]};
        2'h1: o_chroma_out <= {out_uv.u[5:4], out_uv.v[5:4]};
        2'h2: o_chroma_out <= {out_uv.u[3:2], out_uv.v[3:2]};
        default: o_chroma_out <= {out_uv.u[1:0], out_uv.v[1:0]};
      endcase
    end
  end

  // RULE14: fixed input delay aligned to quarter phase
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vs_act <= 1'b0;
      vs_act_q <= 1'b0;
    end else begin
      if (vs_edge) begin
        vs_act <= 1'b1;
      end else if (quarter_rate_clock) begin
        vs_act <= 1'b0;
      end
      vs_act_q <= vs_act && quarter_rate_clock;
    end
  end

  // RULE13: programmable delay
  // RULE24: total vertical delay
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      vdly_cnt <= 14'h0000;
      vdly_run <= 1'b0;
      internal_vsync <= 1'b1;
      vs_lvl <= 1'b1;
    end else begin
      vs_lvl <= 1'b1;
      if (vs_act_q) begin
        vdly_cnt <= 14'(int'(vsync_delay) * vidcap_pkg::VSYNC_STEP_CLKS);
        vdly_run <= 1'b1;
      end else if (vdly_run) begin
        if (vdly_cnt == 14'h0000) begin
          vdly_run <= 1'b0;
          vs_lvl <= 1'b0;
        end else begin
          vdly_cnt <= vdly_cnt - 14'h0001;
        end
      end
      internal_vsync <= vs_lvl;
    end
  end

  assign o_internal_vsync = internal_vsync;
  logic ivs_fall;
  assign ivs_fall = internal_vsync && !vs_lvl;

  // RULE23: blank line counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      blank_cnt <= 10'h000;
    end else if (ivs_fall) begin
      blank_cnt <= 10'h000;
    end else if (hs_edge) begin
      blank_cnt <= blank_cnt + 10'h001;
    end
  end
  assign o_input_blank_lines = blank_cnt;

  // RULE17: field identification
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      fid_cnt <= 12'h000;
      fid_run <= 1'b0;
      field_b <= 1'b0;
    end else if (ivs_fall) begin
      fid_cnt <= 12'h000;
      fid_run <= 1'b1;
    end else if (fid_run) begin
      fid_cnt <= fid_cnt + 12'h001;
      if (hs_edge) begin
        fid_run <= 1'b0;
        field_b <= fid_cnt > 12'(vidcap_pkg::FIELD_SAMPLE_CLKS / 2);
      end
    end
  end
  assign o_field_b = field_b;

  // RULE18: output field sequence
  // RULE19: output syncs
  logic [1:0] seq;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      seq <= 2'h0;
      o_vsync_out <= 1'b0;
      o_hsync_out <= 1'b0;
      o_interlaced <= 1'b0;
    end else begin
      o_hsync_out <= hs_edge || (h_armed && hcnt < 16'(vidcap_pkg::VSYNC_STEP_CLKS));
      o_vsync_out <= ivs_fall;
      if (ivs_fall) begin
        seq <= seq + (i_mode_progressive ? 2'h2 : 2'h1);
        o_interlaced <= i_mode_progressive ? 1'b0 : seq[0];
      end
    end
  end

endmodule // vidcap_top

// File: tb/vidcap_asserts.sv
module vidcap_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Inputs
  input wire logic i_sync_gate_n,
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  // Outputs
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] o_luma_out,
  input wire logic o_vsync_out,
  input wire logic o_hsync_out,
  input wire logic o_interlaced,
  input wire logic o_internal_vsync,
  input wire logic o_internal_hsync,
  input wire logic [9:0] o_input_blank_lines,
  input wire logic [9:0] o_pixel_count
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_reg_default: assert property (
    !$past(i_resetn) && i_reg_addr == 8'h09 |-> o_reg_rdata == 8'h3a) else $error("reg default");
  chk_reg_write: assert property (
    i_reg_we && i_reg_addr == 8'h09 ##1 i_reg_addr == 8'h09 |-> o_reg_rdata == $past(i_reg_wdata))
    else $error("reg write lost");
  chk_unmapped_zero: assert property (
    i_reg_addr != 8'h09 |-> o_reg_rdata == 8'h00) else $error("unmapped read");
  chk_gate_blocks: assert property (
    i_sync_gate_n [*5] |-> !o_internal_hsync) else $error("sync through closed gate");
  chk_vs_one_clk: assert property (
    $fell(o_internal_vsync) |=> o_internal_vsync) else $error("vsync pulse long");
  chk_vs_out: assert property (
    $fell(o_internal_vsync) |-> ##[0:1] o_vsync_out) else $error("no vsync out");
  chk_hsync_out_follow: assert property (
    o_internal_hsync |=> o_hsync_out) else $error("no hsync out");
  chk_ilace_step: assert property (
    $changed(o_interlaced) |-> o_vsync_out) else $error("interlace moved off field start");
  chk_blank_hold: assert property (
    (!o_internal_hsync && o_internal_vsync) [*2] ##1 o_internal_vsync
      |-> $stable(o_input_blank_lines)) else $error("blank count moved");
  chk_pixel_max: assert property (
    o_pixel_count <= 10'h2d0) else $error("pixel count over");
  chk_luma_rate: assert property (
    $changed(o_luma_out) |=> $stable(o_luma_out)) else $error("luma too fast");
  chk_reset_state: assert property (
    !$past(i_resetn) |-> o_internal_vsync && !o_vsync_out && o_pixel_count == 10'h000)
    else $error("reset state");
  cov_vs_fall: cover property ($fell(o_internal_vsync));
  cov_full_line: cover property (o_pixel_count == 10'h2d0);
  cov_reg_write: cover property (i_reg_we && i_reg_addr == 8'h09);
endmodule // vidcap_asserts

bind vidcap_top vidcap_asserts u_chk (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_sync_gate_n(i_sync_gate_n),
  .i_reg_we(i_reg_we),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata),
  .o_luma_out(o_luma_out),
  .o_vsync_out(o_vsync_out),
  .o_hsync_out(o_hsync_out),
  .o_interlaced(o_interlaced),
  .o_internal_vsync(o_internal_vsync),
  .o_internal_hsync(o_internal_hsync),
  .o_input_blank_lines(o_input_blank_lines),
  .o_pixel_count(o_pixel_count)
);

// File: tb/vidcap_frontend.sv
module vidcap_frontend (
  // Clock
  input wire logic i_clk,
  // Pins towards the device
  output logic o_hsync,
  output logic o_vsync,
  output logic o_gate_n,
  output logic [7:0] o_luma,
  output logic [3:0] o_chroma
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hpol = 1'b0;
  logic vpol = 1'b0;
  logic slow = 1'b0;
  logic gate_hold = 1'b0;
  logic go = 1'b0;
  logic [7:0] junk = 8'h00;
  int t = -1;
  int d = 65;
  initial begin
    o_hsync = 1'b1;
    o_vsync = 1'b1;
    o_gate_n = 1'b0;
    o_luma = 8'h00;
    o_chroma = 4'h0;
  end
  always @(negedge i_clk) begin
    o_gate_n <= gate_hold | (slow & ~o_gate_n);
  end
  // Data outside the active part changes every cycle so stale samples show up.
  // placed active data.
  always @(negedge i_clk) begin
    junk <= junk + 8'h25;
    o_hsync <= (t >= 0 && t < 16) ? hpol : ~hpol;
    // A slow frontend starts its sync while the gate is open, so the edge is seen at once.
    if (go && t < 0 && !(slow && o_gate_n)) t <= 0;
    else if (t >= 0) t <= (t > d + 1500) ? -1 : t + 1;
    if (t >= d && t < d + 1440) begin
      o_luma <= 8'h5c;
      o_chroma <= ((t - d) % 8 < 2) ? 4'b1000 : 4'b0000;
    end else begin
      o_luma <= junk;
      o_chroma <= junk[3:0];
    end
  end
  task automatic start_line(input int dly);
    d = dly;
    @(posedge i_clk) go = 1'b1;
    @(posedge i_clk);
    // A slow gate may hold the start back by one cycle.
    if (t < 0) @(posedge i_clk);
    go = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic vs_level(input logic act);
    @(negedge i_clk) o_vsync <= act ? vpol : ~vpol;
  endtask
endmodule // vidcap_frontend

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hs, vs, gate_n, int_vs, field_b;
  logic avo, ilace;
  logic prog = 1'b0;
  logic [7:0] luma, rdata, luma_out;
  logic [3:0] chroma, chroma_out;
  logic [9:0] pix;
  vidcap_pkg::vidcap_cfg_t cfg = '0;
  logic [7:0] coarse = 8'h00;
  logic [5:0] phase = 6'h00;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  int err_count = 0;
  int checks_done = 0;
  // only cycle counts matter here, so the period merely scales time.
  always #5 clk = ~clk;
  vidcap_frontend u_fe (.i_clk(clk), .o_hsync(hs), .o_vsync(vs), .o_gate_n(gate_n),
    .o_luma(luma), .o_chroma(chroma));
  vidcap_top u_dut (.i_clk(clk), .i_resetn(resetn), .i_hsync_in(hs), .i_vsync_in(vs),
    .i_sync_gate_n(gate_n), .i_luma_in(luma), .i_chroma_in(chroma), .i_cfg(cfg),
    .i_hsync_delay_coarse(coarse), .i_input_pixel_phase(phase), .i_reg_we(we),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_mode_progressive(prog),
    .o_luma_out(luma_out), .o_chroma_out(chroma_out), .o_active_video_out(avo), .o_hsync_out(),
    .o_vsync_out(), .o_interlaced(ilace), .o_internal_vsync(int_vs), .o_internal_hsync(),
    .o_field_b(field_b), .o_input_blank_lines(), .o_pixel_count(pix));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) addr = a;
    #1 check(rdata === exp, "register read");
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) we = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk) we = 1'b0;
  endtask
  task automatic test_regs();
    reg_check(8'h09, 8'h3a);
    reg_check(8'h08, 8'h00);
    reg_write(8'h09, 8'h5a);
    reg_write(8'h0a, 8'hff);
    reg_check(8'h0a, 8'h00);
    reg_check(8'h09, 8'h5a);
  endtask
  task automatic test_vs(input logic pol, input logic [7:0] val, input logic hold, input int gap,
    input logic fb);
    int n;
    int lo;
    lo = val * 32 + 7;
    cfg.vsync_in_polarity = pol;
    prog = pol;
    u_fe.vpol = pol;
    u_fe.vs_level(1'b0);
    reg_write(8'h09, val);
    u_fe.gate_hold = hold;
    // A line started behind the closed gate must not begin a capture.
    if (hold) u_fe.start_line(65);
    repeat (lo + 40) @(negedge clk);
    u_fe.vs_level(1'b1);
    for (n = 1; n < lo + 40; n++) begin
      @(negedge clk);
      if (int_vs === 1'b0) break;
    end
    if (hold) check(n == lo + 40, "edge passed closed gate");
    if (hold) check(pix === 10'h2d0, "line began through closed gate");
    else check(n >= lo && n <= lo + 4, "vertical delay");
    if (!hold && n == lo + 40) tally_and_finish();
    if (!hold) begin
      repeat (gap) @(negedge clk);
      u_fe.start_line(65);
      repeat (1000 - gap) @(negedge clk);
      check(field_b === fb, "field identity");
      if (prog) check(ilace === 1'b0, "interlace flag in progressive mode");
      repeat (700 + gap) @(negedge clk);
    end else begin
      repeat (1400) @(negedge clk);
    end
    u_fe.vs_level(1'b0);
    repeat (20) @(negedge clk);
    u_fe.gate_hold = 1'b0;
  endtask
  task automatic test_line(input logic [7:0] c, input logic [5:0] p, input logic sl);
    int n;
    int d;
    int seen;
    int bad;
    int hole;
    d = c * 64 + p + 65;
    seen = 0;
    bad = 0;
    hole = 0;
    coarse = c;
    phase = p;
    cfg.chroma_in_signed = 1'b1;
    cfg.chroma_out_signed = 1'b0;
    u_fe.slow = sl;
    repeat (20) @(negedge clk);
    u_fe.start_line(d);
    for (n = 1; n < d + 40; n++) begin
      @(negedge clk);
      if (pix === 10'h001) break;
    end
    check(n >= d + 1 && n <= d + 2, "first pixel position");
    for (n = 0; n < 1500; n++) begin
      @(negedge clk);
      if (luma_out === 8'h5c) seen |= 1;
      if (chroma_out === 4'b0010) seen |= 2;
      if (pix > 10'h008 && pix < 10'h2c8 && chroma_out !== 4'b0010 && chroma_out !== 4'h0) bad++;
      if (pix > 10'h008 && pix < 10'h2c8 && avo !== 1'b1) hole++;
    end
    check(hole == 0, "active video missing");
    check(seen == 3, "luma or chroma missing");
    check(bad == 0, "chroma pairing");
    check(pix === 10'h2d0, "pixel count");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    test_regs();
    test_vs(1'b0, 8'h01, 1'b0, 100, 1'b0);
    test_vs(1'b1, 8'h3a, 1'b0, 600, 1'b1);
    test_vs(1'b0, 8'h02, 1'b1, 0, 1'b0);
    test_line(8'h01, 6'h03, 1'b0);
    test_line(8'h00, 6'h00, 1'b1);
    tally_and_finish();
  end
endmodule // testbench
